// >>> rtl/cbc_pkg.sv
// package: constants and types shared by the card bus crc and power-up block
package cbc_pkg;
  // ----------------------------------------------------------------
  // frame check codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam int CMD_BITS = 48;
  localparam int MSG_BITS = 40;
  localparam int CRC16_BITS = 16;
  localparam int MAX_BLK_BYTES = 2048;
  localparam int DEF_BLK_BYTES = 512;
  // ----------------------------------------------------------------
  // power-up and turnaround counts, in link clocks
  // ----------------------------------------------------------------
  localparam int INIT_ONES = 64;
  localparam int TURN_CLKS = 2;
  localparam int TOK_GAP = 2;
  // ----------------------------------------------------------------
  // command indices and response fields
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_GO_IDLE = 6'h00;
  localparam logic [5:0] IDX_SEND_OP_COND = 6'h01;
  localparam logic [5:0] IDX_READ_BLOCK = 6'h11;
  localparam logic [5:0] IDX_WRITE_BLOCK = 6'h18;
  localparam logic [5:0] IDX_CRC_ON_OFF = 6'h3b;
  localparam logic [5:0] IDX_R3 = 6'h3f;
  localparam int STAT_CRC_ERR_BIT = 23;
  localparam int STAT_READY_BIT = 8;
  localparam int OCR_READY_BIT = 31;
  localparam logic [30:0] OCR_VOLT_DEF = 31'h00ff_8000;
  localparam logic CRC_EN_RST = 1'b1;
  localparam logic [2:0] TOK_ACCEPT = 3'h2;
  localparam logic [2:0] TOK_REJECT = 3'h5;
  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    cbc_l_init, cbc_l_idle, cbc_l_cmd, cbc_l_turn, cbc_l_resp,
    cbc_l_rdwait, cbc_l_rdsend, cbc_l_rdcrc, cbc_l_wrwait, cbc_l_wrrecv, cbc_l_wrtok
  } cbc_lstate_t;
  localparam int OP_NONE = 0;
  localparam int OP_READ = 1;
  localparam int OP_WRITE = 2;
endpackage : cbc_pkg

// >>> rtl/cbc_fifo.sv
// synchronous fifo with valid and ready on both sides
module cbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("cbc_fifo: depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem_r[rp_r[AW-1:0]];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r[AW-1:0]] = in_data;
    end
    wp_nxt = push ? (AW + 1)'(1) + wp_r : wp_r;
    rp_nxt = pop ? (AW + 1)'(1) + rp_r : rp_r;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (clk_en) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset: reads are gated by the pointers
  always_ff @(posedge clock) begin
    if (clk_en) begin
      mem_r <= mem_nxt;
    end
  end
endmodule : cbc_fifo

// >>> rtl/cbc_card_link.sv
// card side of the serial bus: frame crc, power-up handshake, block crc
// Notes on behaviour
// - check crc7 of every received command while crc checking is on
// - append crc7 to every transmitted response
// - crc7 uses x^7+x^3+1 over 40 bits
// - read blocks end with sixteen crc bits
// - crc16 uses x^16+x^12+x^5+1, 2048 bytes; the code covers BLK_BYTES bytes, 512 by default, at most 2048
// - crc7 checking follows the crc on/off bit; crc16 is always generated and checked
// - power-on reset input defines state, held low
// - go-idle command returns card to idle
// - ignore everything until send-op-cond after power-up
// - op-cond reply carries voltage profile, busy flag
// - ready after sixty-four ones of the run
// - failed command check sets crc error status
// - bad write block answered with status 101
// - crc on/off command option bit enables checking
module cbc_card_link #(
  parameter int BLK_BYTES = cbc_pkg::DEF_BLK_BYTES,
  parameter int FIFO_DEPTH = 16,
  parameter logic [30:0] OCR_VOLT = cbc_pkg::OCR_VOLT_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe_n,
  input wire logic dat_in,
  output logic dat_out,
  output logic dat_oe_n,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic core_ready,
  output logic card_active
);
  if (BLK_BYTES < 1 || BLK_BYTES > cbc_pkg::MAX_BLK_BYTES) begin : g_bad_blk
    $error("cbc_card_link: bad block length");
  end
  localparam logic [11:0] BLK_W = 12'(BLK_BYTES);
  localparam logic [14:0] WR_LAST = 15'(BLK_BYTES * 8 + cbc_pkg::CRC16_BITS - 1);

  function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
    crc7_step = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? cbc_pkg::CRC7_POLY : 7'h00);
  endfunction : crc7_step

  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
    crc16_step = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? cbc_pkg::CRC16_POLY : 16'h0000);
  endfunction : crc16_step

  // ----------------------------------------------------------------
  // system clock side: fifo and byte hand-over
  // ----------------------------------------------------------------
  logic f_valid, f_ready;
  logic [7:0] f_data;
  logic rq_s1_r, rq_s2_r, rq_seen_r, rq_seen_nxt;
  logic ack_t_r, ack_t_nxt;
  logic [7:0] xb_r, xb_nxt;
  logic ca_s1_r, ca_s2_r;
  logic active_r;
  logic req_t_r;

  cbc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .in_data(rd_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // one byte per request toggle; the byte is held stable until the next one
  assign f_ready = (rq_s2_r != rq_seen_r) && f_valid;
  assign card_active = ca_s2_r;

  always_comb begin
    rq_seen_nxt = rq_seen_r;
    ack_t_nxt = ack_t_r;
    xb_nxt = xb_r;
    if (f_ready) begin
      rq_seen_nxt = rq_s2_r;
      ack_t_nxt = ~ack_t_r;
      xb_nxt = f_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_seen_r <= 1'b0;
      ack_t_r <= 1'b0;
      xb_r <= 8'h00;
      ca_s1_r <= 1'b0;
      ca_s2_r <= 1'b0;
    end else if (clk_en) begin
      rq_s1_r <= req_t_r;
      rq_s2_r <= rq_s1_r;
      rq_seen_r <= rq_seen_nxt;
      ack_t_r <= ack_t_nxt;
      xb_r <= xb_nxt;
      ca_s1_r <= active_r;
      ca_s2_r <= ca_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // link clock side: synchronisers
  // ----------------------------------------------------------------
  logic lr_s1_r, lr_s2_r, cmd_s1_r, cmd_s2_r, dat_s1_r, dat_s2_r;
  logic rdy_s1_r, rdy_s2_r, ack_s1_r, ack_s2_r;

  always_ff @(posedge link_clk) begin
    lr_s1_r <= rst_n;
    lr_s2_r <= lr_s1_r;
    cmd_s1_r <= cmd_in;
    cmd_s2_r <= cmd_s1_r;
    dat_s1_r <= dat_in;
    dat_s2_r <= dat_s1_r;
    rdy_s1_r <= core_ready;
    rdy_s2_r <= rdy_s1_r;
    ack_s1_r <= ack_t_r;
    ack_s2_r <= ack_s1_r;
  end

  // ----------------------------------------------------------------
  // link clock side: frame engine
  // ----------------------------------------------------------------
  cbc_pkg::cbc_lstate_t st_r, st_nxt;
  logic [14:0] cnt_r, cnt_nxt;
  logic [47:0] sh_r, sh_nxt;
  logic [6:0] crc7_r, crc7_nxt;
  logic [15:0] crc16_r, crc16_nxt;
  logic active_nxt, crc_en_r, crc_en_nxt, crc_err_r, crc_err_nxt;
  logic [1:0] op_r, op_nxt;
  logic [7:0] dsh_r, dsh_nxt, nb_r, nb_nxt;
  logic nb_ok_r, nb_ok_nxt, req_t_nxt, ack_seen_r, ack_seen_nxt;
  logic [11:0] bytes_r, bytes_nxt;
  logic [2:0] tok_r, tok_nxt;
  logic cmd_o_r, cmd_o_nxt, cmd_oe_n_r, cmd_oe_n_nxt;
  logic dat_o_r, dat_o_nxt, dat_oe_n_r, dat_oe_n_nxt;

  assign cmd_out = cmd_o_r;
  assign cmd_oe_n = cmd_oe_n_r;
  assign dat_out = dat_o_r;
  assign dat_oe_n = dat_oe_n_r;

  always_comb begin
    logic [47:0] frame;
    logic [5:0] idx;
    logic [31:0] body;
    logic crc_ok;
    frame = {sh_r[46:0], cmd_s2_r};
    idx = frame[45:40];
    body = 32'h0000_0000;
    crc_ok = (frame[7:1] == crc7_r) || !crc_en_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    crc7_nxt = crc7_r;
    crc16_nxt = crc16_r;
    active_nxt = active_r;
    crc_en_nxt = crc_en_r;
    crc_err_nxt = crc_err_r;
    op_nxt = op_r;
    dsh_nxt = dsh_r;
    nb_nxt = nb_r;
    nb_ok_nxt = nb_ok_r;
    req_t_nxt = req_t_r;
    ack_seen_nxt = ack_seen_r;
    bytes_nxt = bytes_r;
    tok_nxt = tok_r;
    cmd_o_nxt = 1'b1;
    cmd_oe_n_nxt = 1'b1;
    dat_o_nxt = 1'b1;
    dat_oe_n_nxt = 1'b1;
    if (ack_s2_r != ack_seen_r) begin
      ack_seen_nxt = ack_s2_r;
      nb_nxt = xb_r;
      nb_ok_nxt = 1'b1;
    end
    case (st_r)
      cbc_pkg::cbc_l_init: begin
        // a zero breaks the run, so counting restarts
        cnt_nxt = cmd_s2_r ? 15'(cnt_r + 15'h0001) : 15'h0000;
        if (cmd_s2_r && cnt_r == 15'(cbc_pkg::INIT_ONES - 1)) begin
          st_nxt = cbc_pkg::cbc_l_idle;
        end
      end
      cbc_pkg::cbc_l_idle: begin
        if (!cmd_s2_r) begin
          st_nxt = cbc_pkg::cbc_l_cmd;
          sh_nxt = 48'h0000_0000_0000;
          crc7_nxt = crc7_step(7'h00, 1'b0);
          cnt_nxt = 15'h0001;
        end
      end
      cbc_pkg::cbc_l_cmd: begin
        sh_nxt = frame;
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r < 15'(cbc_pkg::MSG_BITS)) begin
          crc7_nxt = crc7_step(crc7_r, cmd_s2_r);
        end
        if (cnt_r == 15'(cbc_pkg::CMD_BITS - 1)) begin
          st_nxt = cbc_pkg::cbc_l_idle;
          cnt_nxt = 15'h0000;
          if (!crc_ok) begin
            crc_err_nxt = 1'b1;
          end else if (idx == cbc_pkg::IDX_GO_IDLE) begin
            active_nxt = 1'b0;
            crc_en_nxt = cbc_pkg::CRC_EN_RST;
            crc_err_nxt = 1'b0;
          end else if (active_r || idx == cbc_pkg::IDX_SEND_OP_COND) begin
            st_nxt = cbc_pkg::cbc_l_turn;
            op_nxt = 2'(cbc_pkg::OP_NONE);
            crc_err_nxt = 1'b0;
            body[cbc_pkg::STAT_CRC_ERR_BIT] = crc_err_r;
            body[cbc_pkg::STAT_READY_BIT] = 1'b1;
            if (idx == cbc_pkg::IDX_SEND_OP_COND) begin
              active_nxt = 1'b1;
              body = {rdy_s2_r, OCR_VOLT};
              idx = cbc_pkg::IDX_R3;
            end else if (idx == cbc_pkg::IDX_CRC_ON_OFF) begin
              crc_en_nxt = frame[8];
            end else if (idx == cbc_pkg::IDX_READ_BLOCK) begin
              op_nxt = 2'(cbc_pkg::OP_READ);
              nb_ok_nxt = 1'b0;
              req_t_nxt = ~req_t_r;
            end else if (idx == cbc_pkg::IDX_WRITE_BLOCK) begin
              op_nxt = 2'(cbc_pkg::OP_WRITE);
            end
            sh_nxt = {2'b00, idx, body, 8'h00};
          end
        end
      end
      cbc_pkg::cbc_l_turn: begin
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r == 15'(cbc_pkg::TURN_CLKS - 1)) begin
          st_nxt = cbc_pkg::cbc_l_resp;
          cnt_nxt = 15'h0000;
          crc7_nxt = 7'h00;
        end
      end
      cbc_pkg::cbc_l_resp: begin
        // our own drive echoes back through the synchroniser; idle waits two clocks so it is no start bit
        cmd_oe_n_nxt = cnt_r >= 15'(cbc_pkg::CMD_BITS);
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r < 15'(cbc_pkg::MSG_BITS)) begin
          cmd_o_nxt = sh_r[47];
          sh_nxt = {sh_r[46:0], 1'b0};
          crc7_nxt = crc7_step(crc7_r, sh_r[47]);
        end else if (cnt_r < 15'(cbc_pkg::CMD_BITS - 1)) begin
          cmd_o_nxt = crc7_r[6];
          crc7_nxt = {crc7_r[5:0], 1'b0};
        end else if (cnt_r == 15'(cbc_pkg::CMD_BITS + 1)) begin
          cnt_nxt = 15'h0000;
          st_nxt = (op_r == 2'(cbc_pkg::OP_READ)) ? cbc_pkg::cbc_l_rdwait
                 : (op_r == 2'(cbc_pkg::OP_WRITE)) ? cbc_pkg::cbc_l_wrwait : cbc_pkg::cbc_l_idle;
        end
      end
      cbc_pkg::cbc_l_rdwait: begin
        // the start bit waits for the first byte; later bytes must keep pace
        if (nb_ok_r) begin
          st_nxt = cbc_pkg::cbc_l_rdsend;
          dat_oe_n_nxt = 1'b0;
          dat_o_nxt = 1'b0;
          dsh_nxt = nb_r;
          nb_ok_nxt = 1'b0;
          bytes_nxt = 12'h000;
          cnt_nxt = 15'h0000;
          crc16_nxt = 16'h0000;
          if (BLK_W > 12'h001) begin
            req_t_nxt = ~req_t_r;
          end
        end
      end
      cbc_pkg::cbc_l_rdsend: begin
        dat_oe_n_nxt = 1'b0;
        dat_o_nxt = dsh_r[7];
        dsh_nxt = {dsh_r[6:0], 1'b0};
        crc16_nxt = crc16_step(crc16_r, dsh_r[7]);
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r[2:0] == 3'h7) begin
          bytes_nxt = 12'(bytes_r + 12'h001);
          if (12'(bytes_r + 12'h001) < BLK_W) begin
            dsh_nxt = nb_r;
            nb_ok_nxt = 1'b0;
            if (12'(bytes_r + 12'h002) < BLK_W) begin
              req_t_nxt = ~req_t_r;
            end
          end else begin
            st_nxt = cbc_pkg::cbc_l_rdcrc;
            cnt_nxt = 15'h0000;
          end
        end
      end
      cbc_pkg::cbc_l_rdcrc: begin
        dat_oe_n_nxt = 1'b0;
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r < 15'(cbc_pkg::CRC16_BITS)) begin
          dat_o_nxt = crc16_r[15];
          crc16_nxt = {crc16_r[14:0], 1'b0};
        end else begin
          st_nxt = cbc_pkg::cbc_l_idle;
        end
      end
      cbc_pkg::cbc_l_wrwait: begin
        if (!dat_s2_r) begin
          st_nxt = cbc_pkg::cbc_l_wrrecv;
          cnt_nxt = 15'h0000;
          crc16_nxt = 16'h0000;
        end
      end
      cbc_pkg::cbc_l_wrrecv: begin
        // data and its check bits run through one register; zero left means intact
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r <= WR_LAST) begin
          crc16_nxt = crc16_step(crc16_r, dat_s2_r);
        end else begin
          st_nxt = cbc_pkg::cbc_l_wrtok;
          cnt_nxt = 15'h0000;
          tok_nxt = (crc16_r == 16'h0000) ? cbc_pkg::TOK_ACCEPT : cbc_pkg::TOK_REJECT;
        end
      end
      cbc_pkg::cbc_l_wrtok: begin
        cnt_nxt = 15'(cnt_r + 15'h0001);
        if (cnt_r >= 15'(cbc_pkg::TOK_GAP)) begin
          dat_oe_n_nxt = 1'b0;
          if (cnt_r == 15'(cbc_pkg::TOK_GAP)) begin
            dat_o_nxt = 1'b0;
          end else if (cnt_r < 15'(cbc_pkg::TOK_GAP + 4)) begin
            dat_o_nxt = tok_r[2];
            tok_nxt = {tok_r[1:0], 1'b0};
          end else begin
            st_nxt = cbc_pkg::cbc_l_idle;
          end
        end
      end
      default: begin
        st_nxt = cbc_pkg::cbc_l_init;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!lr_s2_r) begin
      st_r <= cbc_pkg::cbc_l_init;
      cnt_r <= 15'h0000;
      sh_r <= 48'h0000_0000_0000;
      crc7_r <= 7'h00;
      crc16_r <= 16'h0000;
      active_r <= 1'b0;
      crc_en_r <= cbc_pkg::CRC_EN_RST;
      crc_err_r <= 1'b0;
      op_r <= 2'(cbc_pkg::OP_NONE);
      dsh_r <= 8'h00;
      nb_r <= 8'h00;
      nb_ok_r <= 1'b0;
      req_t_r <= 1'b0;
      ack_seen_r <= 1'b0;
      bytes_r <= 12'h000;
      tok_r <= 3'h0;
      cmd_o_r <= 1'b1;
      cmd_oe_n_r <= 1'b1;
      dat_o_r <= 1'b1;
      dat_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      crc7_r <= crc7_nxt;
      crc16_r <= crc16_nxt;
      active_r <= active_nxt;
      crc_en_r <= crc_en_nxt;
      crc_err_r <= crc_err_nxt;
      op_r <= op_nxt;
      dsh_r <= dsh_nxt;
      nb_r <= nb_nxt;
      nb_ok_r <= nb_ok_nxt;
      req_t_r <= req_t_nxt;
      ack_seen_r <= ack_seen_nxt;
      bytes_r <= bytes_nxt;
      tok_r <= tok_nxt;
      cmd_o_r <= cmd_o_nxt;
      cmd_oe_n_r <= cmd_oe_n_nxt;
      dat_o_r <= dat_o_nxt;
      dat_oe_n_r <= dat_oe_n_nxt;
    end
  end
endmodule : cbc_card_link

// >>> tb/cbc_chk.sv
// checker: response, block and token framing at the card link pins
module cbc_chk #(
  parameter int BLK_BYTES = 512
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cmd_out,
  input wire logic cmd_oe_n,
  input wire logic dat_out,
  input wire logic dat_oe_n,
  input wire logic rd_ready,
  input wire logic card_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // helper: run lengths and response crc
  // ----------------------------------------------------------------
  logic [15:0] ccnt_r;
  logic [15:0] dcnt_r;
  logic [6:0] crc_r;
  logic bad_r;
  // crc is rebuilt from the wire, so a wrong polynomial or seed shows up
  always_ff @(posedge link_clk) begin
    if (!rst_n || cmd_oe_n) begin
      ccnt_r <= 16'h0000;
      crc_r <= 7'h00;
      bad_r <= 1'b0;
    end else begin
      ccnt_r <= ccnt_r + 16'h0001;
      if (ccnt_r < 16'h0028) begin
        crc_r <= {crc_r[5:0], 1'b0} ^ ((cmd_out ^ crc_r[6]) ? cbc_pkg::CRC7_POLY : 7'h00);
      end else if (ccnt_r < 16'h002f) begin
        bad_r <= bad_r | (cmd_out ^ crc_r[6]);
        crc_r <= {crc_r[5:0], 1'b0};
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!rst_n || dat_oe_n) begin
      dcnt_r <= 16'h0000;
    end else begin
      dcnt_r <= dcnt_r + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_resp_start: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(cmd_oe_n) |-> !cmd_out ##1 (!cmd_out && !cmd_oe_n)) else $error("response start bits wrong");
  chk_resp_len: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(cmd_oe_n) |-> ccnt_r == 16'h0030) else $error("response length not 48");
  chk_resp_end: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(cmd_oe_n) |-> $past(cmd_out)) else $error("response end bit low");
  chk_resp_crc: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(cmd_oe_n) |-> !bad_r) else $error("response crc7 wrong");
  chk_blk_start: assert property (@(posedge link_clk) disable iff (!rst_n)
    $fell(dat_oe_n) |-> !dat_out) else $error("data start bit high");
  chk_blk_end: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(dat_oe_n) |-> $past(dat_out)) else $error("data end bit low");
  chk_blk_len: assert property (@(posedge link_clk) disable iff (!rst_n)
    $rose(dat_oe_n) |-> dcnt_r == 16'h0005 || dcnt_r == 16'(8 * BLK_BYTES + 18))
    else $error("data drive length wrong");
  chk_reset_state: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> !card_active && rd_ready) else $error("state after reset wrong");
endmodule : cbc_chk

bind cbc_card_link cbc_chk #(.BLK_BYTES(BLK_BYTES)) u_chk (
  .clock(clock), .rst_n(rst_n), .link_clk(link_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
  .dat_out(dat_out), .dat_oe_n(dat_oe_n), .rd_ready(rd_ready), .card_active(card_active)
);

// >>> tb/cbc_host.sv
// host model: bus clock, commands, write blocks, reply capture
module cbc_host (
  output logic link_clk,
  output logic cmd_in,
  output logic dat_in,
  input wire logic cmd_out,
  input wire logic cmd_oe_n,
  input wire logic dat_out,
  input wire logic dat_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cmd_h = 1'b1;
  logic dat_h = 1'b1;
  // lines carry pull-ups, so a released line reads high
  assign cmd_in = cmd_oe_n ? cmd_h : cmd_out;
  assign dat_in = dat_oe_n ? dat_h : dat_out;
  // free running: the card needs clocks for sync and turnaround between frames
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? cbc_pkg::CRC7_POLY : 7'h00);
    return c;
  endfunction : crc7
  function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((b[i] ^ c[15]) ? cbc_pkg::CRC16_POLY : 16'h0000);
    return c;
  endfunction : c16
  task automatic clk(input int n);
    repeat (n) @(posedge link_clk);
  endtask : clk
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
    logic [47:0] f;
    f = {2'b01, idx, arg, 8'h01};
    f[7:1] = crc7(f[47:8]) ^ {6'h00, bad};
    for (int i = 47; i >= 0; i--) begin
      @(posedge link_clk);
      cmd_h <= f[i];
    end
    clk(1);
  endtask : send_cmd
  task automatic get_resp(output logic [47:0] r, output logic got);
    got = 1'b0;
    r = 48'h0000_0000_0000;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge link_clk);
      got = (cmd_oe_n === 1'b0);
    end
    for (int i = 47; i >= 0 && got; i--) begin
      if (i < 47) @(posedge link_clk);
      r[i] = cmd_out;
    end
    clk(3);
  endtask : get_resp
  task automatic get_dat(input int n, output logic q[$]);
    q = {};
    for (int i = 0; i < 400; i++) begin
      @(posedge link_clk);
      if (dat_oe_n === 1'b0) break;
    end
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(posedge link_clk);
      q.push_back(dat_oe_n === 1'b0 ? dat_out : 1'bx);
    end
  endtask : get_dat
  task automatic send_blk(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    logic q[$];
    c = 16'h0000;
    q = {1'b0};
    foreach (b[i]) c = c16(c, b[i]);
    c = c ^ {15'h0000, bad};
    foreach (b[i]) for (int k = 7; k >= 0; k--) q.push_back(b[i][k]);
    for (int k = 15; k >= 0; k--) q.push_back(c[k]);
    q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge link_clk);
      dat_h <= q[i];
    end
    clk(1);
  endtask : send_blk
endmodule : cbc_host

// >>> tb/tb.sv
// testbench: power-up handshake, frame crc and block crc of the card link
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BLK = 16;
  int failures = 0;
  int total_checks = 0;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic core_ready = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic rd_valid = 1'b0;
  wire logic link_clk, cmd_in, cmd_out, cmd_oe_n, dat_in, dat_out, dat_oe_n, rd_ready, card_active;
  always #25 clock = ~clock;
  cbc_card_link #(.BLK_BYTES(BLK)) u_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .link_clk(link_clk), .cmd_in(cmd_in),
    .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dat_in(dat_in), .dat_out(dat_out), .dat_oe_n(dat_oe_n),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .core_ready(core_ready),
    .card_active(card_active)
  );
  cbc_host u_host (
    .link_clk(link_clk), .cmd_in(cmd_in), .dat_in(dat_in), .cmd_out(cmd_out),
    .cmd_oe_n(cmd_oe_n), .dat_out(dat_out), .dat_oe_n(dat_oe_n)
  );
  function automatic logic [47:0] frm(input logic [5:0] idx, input logic [31:0] body);
    return {2'b00, idx, body, u_host.crc7({2'b00, idx, body}), 1'b1};
  endfunction : frm
  function automatic logic [7:0] bv(input int k);
    return 8'hc3 ^ 8'(k * 37);
  endfunction : bv
  // e of zero means the card must stay silent
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad, input logic [47:0] e);
    logic [47:0] r;
    logic got;
    u_host.send_cmd(idx, arg, bad);
    u_host.get_resp(r, got);
    `CHK("resp_seen", e != 48'h0000_0000_0000, got)
    if (got) `CHK("resp_frame", e, r)
  endtask : cmd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (8) @(posedge clock);
    `CHK("oe_in_reset", 2'b11, {cmd_oe_n, dat_oe_n})
    `CHK("active_in_reset", 1'b0, card_active)
    rst_n <= 1'b1;
  endtask : t_reset
  task automatic t_powerup();
    // ones stay on the line for a full millisecond before the clock count
    #1ms;
    u_host.clk(80);
    cmd(cbc_pkg::IDX_READ_BLOCK, 32'h0000_0000, 1'b0, 48'h0000_0000_0000);
    cmd(cbc_pkg::IDX_SEND_OP_COND, 32'h0000_0000, 1'b0, frm(6'h3f, {1'b0, cbc_pkg::OCR_VOLT_DEF}));
    `CHK("card_active", 1'b1, card_active)
    @(posedge clock);
    core_ready <= 1'b1;
    u_host.clk(4);
    cmd(cbc_pkg::IDX_SEND_OP_COND, 32'h0000_0000, 1'b0, frm(6'h3f, {1'b1, cbc_pkg::OCR_VOLT_DEF}));
  endtask : t_powerup
  task automatic t_crc();
    cmd(6'h3b, 32'h0000_0001, 1'b1, 48'h0000_0000_0000);
    cmd(6'h3b, 32'h0000_0001, 1'b0, frm(6'h3b, 32'h0080_0100));
    cmd(6'h3b, 32'h0000_0000, 1'b0, frm(6'h3b, 32'h0000_0100));
    cmd(6'h3b, 32'h0000_0001, 1'b1, frm(6'h3b, 32'h0000_0100));
    cmd(6'h3b, 32'h0000_0001, 1'b1, 48'h0000_0000_0000);
    cmd(6'h3b, 32'h0000_0001, 1'b0, frm(6'h3b, 32'h0080_0100));
  endtask : t_crc
  task automatic t_read();
    int n;
    logic q[$];
    logic [47:0] r;
    logic got;
    logic [7:0] v;
    logic [15:0] c;
    n = 0;
    c = 16'h0000;
    @(posedge clock);
    // bytes offered while frozen must not enter the fifo, or the block would start with them
    clk_en <= 1'b0;
    rd_valid <= 1'b1;
    rd_data <= 8'hff;
    repeat (3) @(posedge clock);
    clk_en <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      rd_valid <= 1'b1;
      rd_data <= bv(n);
      @(posedge clock);
      if (rd_ready === 1'b1) n++;
    end
    rd_valid <= 1'b0;
    `CHK("fifo_full", 1'b0, rd_ready)
    u_host.send_cmd(cbc_pkg::IDX_READ_BLOCK, 32'h0000_0000, 1'b0);
    fork
      u_host.get_resp(r, got);
      u_host.get_dat(8 * BLK + 18, q);
    join
    `CHK("read_resp", frm(6'h11, 32'h0000_0100), r)
    `CHK("read_start", 1'b0, q[0])
    for (int k = 0; k < BLK; k++) begin
      for (int j = 0; j < 8; j++) v = {v[6:0], q[1 + 8 * k + j]};
      `CHK("read_byte", bv(k), v)
      c = u_host.c16(c, bv(k));
    end
    for (int k = 0; k < 16; k++) c[15 - k] = c[15 - k] ^ q[1 + 8 * BLK + k];
    `CHK("read_crc_diff", 16'h0000, c)
    `CHK("read_end", 1'b1, q[8 * BLK + 17])
    `CHK("fifo_room", 1'b1, rd_ready)
  endtask : t_read
  task automatic t_write();
    logic q[$];
    logic [7:0] b[$];
    for (int k = 0; k < BLK; k++) b.push_back(bv(k + 5));
    for (int bad = 0; bad < 2; bad++) begin
      cmd(cbc_pkg::IDX_WRITE_BLOCK, 32'h0000_0000, 1'b0, frm(6'h18, 32'h0000_0100));
      fork
        u_host.send_blk(b, bad[0]);
        u_host.get_dat(5, q);
      join
      `CHK("token", bad[0] ? 5'h0b : 5'h05, {q[0], q[1], q[2], q[3], q[4]})
    end
  endtask : t_write
  task automatic t_idle();
    cmd(cbc_pkg::IDX_GO_IDLE, 32'h0000_0000, 1'b0, 48'h0000_0000_0000);
    u_host.clk(4);
    `CHK("active_after_idle", 1'b0, card_active)
    cmd(6'h3b, 32'h0000_0001, 1'b0, 48'h0000_0000_0000);
  endtask : t_idle
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_powerup();
    t_crc();
    t_read();
    t_write();
    t_idle();
    final_report();
  end
  // whole run is near 1.25 ms, mostly the run of ones; 3 ms means a hang
  initial begin
    #3ms;
    failures++;
    final_report();
  end
endmodule : tb
